/* shared/tlp_pkg.sv */
package tlp_pkg;

   // ****************************************
   // Sources and register map
   // ****************************************
   localparam int          NSRC          = 8;
   localparam int          EXT_PINS      = 2;
   localparam int          PORT_PINS     = 4;
   localparam int          PERIPH_SRCS   = 5;
   localparam int          SYNC_W        = EXT_PINS + PORT_PINS;
   localparam logic [11:0] OFF_RESET_CTL = 12'h000;
   localparam logic [11:0] OFF_IRQ_CTL   = 12'h004;
   localparam logic [11:0] OFF_FLAG      = 12'h008;
   localparam logic [11:0] OFF_ENABLE    = 12'h00c;
   localparam logic [11:0] OFF_PRIO      = 12'h010;
   localparam logic [11:0] OFF_STATE     = 12'h014;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int          PRIO_MODE_BIT = 7;
   localparam int          HIGH_EN_BIT   = 7;
   localparam int          LOW_EN_BIT    = 6;
   localparam logic [7:0]  PERIPH_MASK   = 8'hf8;
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic        RST_BIT       = 1'h0;

   // ****************************************
   // Vectors and timing
   // ****************************************
   localparam logic [15:0] VEC_HIGH      = 16'h0008;
   localparam logic [15:0] VEC_LOW       = 16'h0018;
   localparam logic [1:0]  DIV_LAST      = 2'h3;
   localparam logic [1:0]  LAT_WAIT      = 2'h2;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tlp_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } tlp_apb_rsp_t;

   typedef struct packed {
      logic        take;
      logic        high;
      logic [15:0] vector;
   } tlp_vec_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_TAKE = 3'b100
   } tlp_state_t;

endpackage

/* rtl/tlp_sync_edge.sv */
`timescale 1ns/1ps
module tlp_sync_edge
   import tlp_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Asynchronous pins
   input  wire logic [SYNC_W-1:0]    pinIn,
   // Synchronised events
   output logic      [EXT_PINS-1:0]  extRise,
   output logic                      portChange
);

   logic [SYNC_W-1:0] meta_ff;
   logic [SYNC_W-1:0] sync_ff;
   logic [SYNC_W-1:0] prev_ff;

   // ****************************************
   // Two-stage synchroniser, then history
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= pinIn;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign extRise    = sync_ff[EXT_PINS-1:0] & ~prev_ff[EXT_PINS-1:0];
   assign portChange = |(sync_ff[SYNC_W-1:EXT_PINS] ^ prev_ff[SYNC_W-1:EXT_PINS]);

endmodule

/* rtl/tlp_qualify.sv */
`timescale 1ns/1ps
module tlp_qualify
   import tlp_pkg::*;
(
   // Source state
   input  wire logic [NSRC-1:0] flag,
   input  wire logic [NSRC-1:0] enable,
   input  wire logic [NSRC-1:0] prio,
   // Global state
   input  wire logic            prioMode,
   input  wire logic            highEn,
   input  wire logic            lowEn,
   input  wire logic            hiActive,
   // Qualified requests
   output logic                 hiReq,
   output logic                 loReq
);

   logic [NSRC-1:0] armed;

   assign armed = flag & enable;

   always_comb begin
      hiReq = 1'b0;
      loReq = 1'b0;
      if (prioMode) begin
         // Low group also needs the high enable, which masks everything
         hiReq = highEn & |(armed & prio);
         loReq = highEn & lowEn & ~hiActive & |(armed & ~prio);
      end else begin
         // One level only; peripheral sources also need the low enable
         hiReq = highEn & |(armed & (~PERIPH_MASK | {NSRC{lowEn}}));
      end
   end

endmodule

/* rtl/tlp_irq_ctrl.sv */
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module tlp_irq_ctrl
   import tlp_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // APB register port
   input  wire tlp_apb_req_t           apbReq,
   output tlp_apb_rsp_t                apbRsp,
   // Interrupt sources
   input  wire logic [EXT_PINS-1:0]    extPins,
   input  wire logic [PORT_PINS-1:0]   portIn,
   input  wire logic [PERIPH_SRCS-1:0] periphEvent,
   // Core sequencer
   input  wire logic                   retFromHandler,
   output tlp_vec_t                    vecReq,
   output logic                        instrCycle,
   // Interrupt level
   output logic                        irqOut
);

   // ****************************************
   // Declarations
   // ****************************************
   tlp_apb_rsp_t      apbRsp_ff;
   tlp_vec_t          vecReq_ff;
   tlp_state_t        state_ff;
   logic [1:0]        divCnt_ff;
   logic              instrEn_ff;
   logic [1:0]        waitCnt_ff;
   logic [NSRC-1:0]   flag_ff;
   logic [NSRC-1:0]   enable_ff;
   logic [NSRC-1:0]   prio_ff;
   logic [NSRC-1:0]   nxt_flag;
   logic              prioMode_ff;
   logic              highEn_ff;
   logic              lowEn_ff;
   logic              nxt_highEn;
   logic              nxt_lowEn;
   logic              hiActive_ff;
   logic              loActive_ff;
   logic              irqOut_ff;
   logic [EXT_PINS-1:0] extRise;
   logic              portChange;
   logic [NSRC-1:0]   srcEvent;
   logic              hiReq;
   logic              loReq;
   logic              anyReq;
   logic              takeNow;
   logic              takeHigh;
   logic              access;
   logic              wrCommit;
   logic [31:0]       rdData;
   logic              mapped;

   function automatic logic regHit(input logic [11:0] addr, input logic [11:0] off);
      regHit = (addr[11:2] == off[11:2]);
   endfunction

   // ****************************************
   // Instruction cycle divider
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         divCnt_ff  <= 2'h0;
         instrEn_ff <= 1'b0;
      end else begin
         divCnt_ff  <= (divCnt_ff == DIV_LAST) ? 2'h0 : divCnt_ff + 2'h1;
         instrEn_ff <= (divCnt_ff == DIV_LAST);
      end
   end

   // ****************************************
   // Sources
   // ****************************************
   tlp_sync_edge u_sync (
      .clk        (clk),
      .rst        (rst),
      .pinIn      ({portIn, extPins}),
      .extRise    (extRise),
      .portChange (portChange)
   );

   assign srcEvent = {periphEvent, portChange, extRise};

   // ****************************************
   // APB slave
   // ****************************************
   assign access   = apbReq.psel & apbReq.penable;
   assign wrCommit = access & apbReq.pwrite & apbRsp_ff.pready;
   assign mapped   = regHit(apbReq.paddr, OFF_RESET_CTL) | regHit(apbReq.paddr, OFF_IRQ_CTL)
                   | regHit(apbReq.paddr, OFF_FLAG) | regHit(apbReq.paddr, OFF_ENABLE)
                   | regHit(apbReq.paddr, OFF_PRIO) | regHit(apbReq.paddr, OFF_STATE);

   always_comb begin
      rdData = 32'h0000_0000;
      if (regHit(apbReq.paddr, OFF_RESET_CTL)) begin
         rdData[PRIO_MODE_BIT] = prioMode_ff;
      end else if (regHit(apbReq.paddr, OFF_IRQ_CTL)) begin
         rdData[HIGH_EN_BIT] = highEn_ff;
         rdData[LOW_EN_BIT]  = lowEn_ff;
      end else if (regHit(apbReq.paddr, OFF_FLAG)) begin
         rdData[NSRC-1:0] = flag_ff;
      end else if (regHit(apbReq.paddr, OFF_ENABLE)) begin
         rdData[NSRC-1:0] = enable_ff;
      end else if (regHit(apbReq.paddr, OFF_PRIO)) begin
         rdData[NSRC-1:0] = prio_ff;
      end else if (regHit(apbReq.paddr, OFF_STATE)) begin
         rdData[0]     = hiActive_ff;
         rdData[1]     = loActive_ff;
         rdData[2]     = hiReq;
         rdData[3]     = loReq;
         rdData[6:4]   = state_ff;
         rdData[31:16] = vecReq_ff.vector;
      end
   end

   // One wait state: answer in the second access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         apbRsp_ff <= '0;
      end else begin
         apbRsp_ff.pready  <= access & ~apbRsp_ff.pready;
         apbRsp_ff.pslverr <= access & ~apbRsp_ff.pready & ~mapped;
         apbRsp_ff.prdata  <= (access & ~apbRsp_ff.pready & ~apbReq.pwrite) ? rdData
                                                                          : 32'h0000_0000;
      end
   end

   // ****************************************
   // Source registers
   // ****************************************
   always_comb begin
      nxt_flag = flag_ff;
      if (wrCommit && regHit(apbReq.paddr, OFF_FLAG)) begin
         nxt_flag = flag_ff & ~apbReq.pwdata[NSRC-1:0];
      end
      nxt_flag = nxt_flag | srcEvent;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_ff <= RST_BYTE;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         enable_ff <= RST_BYTE;
         prio_ff   <= RST_BYTE;
      end else if (wrCommit) begin
         if (regHit(apbReq.paddr, OFF_ENABLE)) begin
            enable_ff <= apbReq.pwdata[NSRC-1:0];
         end
         if (regHit(apbReq.paddr, OFF_PRIO)) begin
            prio_ff <= apbReq.pwdata[NSRC-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prioMode_ff <= RST_BIT;
      end else if (wrCommit && regHit(apbReq.paddr, OFF_RESET_CTL)) begin
         prioMode_ff <= apbReq.pwdata[PRIO_MODE_BIT];
      end
   end

   // ****************************************
   // Global enables
   // ****************************************
   always_comb begin
      nxt_highEn = highEn_ff;
      nxt_lowEn  = lowEn_ff;
      if (wrCommit && regHit(apbReq.paddr, OFF_IRQ_CTL)) begin
         nxt_highEn = apbReq.pwdata[HIGH_EN_BIT];
         nxt_lowEn  = apbReq.pwdata[LOW_EN_BIT];
      end
      if (retFromHandler) begin
         if (hiActive_ff) begin
            nxt_highEn = 1'b1;
         end else if (loActive_ff) begin
            nxt_lowEn = 1'b1;
         end
      end
      // Entry wins over a software write in the same cycle
      if (takeNow) begin
         if (takeHigh) begin
            nxt_highEn = 1'b0;
         end else begin
            nxt_lowEn = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         highEn_ff <= RST_BIT;
         lowEn_ff  <= RST_BIT;
      end else begin
         highEn_ff <= nxt_highEn;
         lowEn_ff  <= nxt_lowEn;
      end
   end

   // ****************************************
   // Handler levels in progress
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         hiActive_ff <= RST_BIT;
         loActive_ff <= RST_BIT;
      end else if (takeNow) begin
         if (takeHigh) begin
            hiActive_ff <= 1'b1;
         end else begin
            loActive_ff <= 1'b1;
         end
      end else if (retFromHandler) begin
         if (hiActive_ff) begin
            hiActive_ff <= 1'b0;
         end else begin
            loActive_ff <= 1'b0;
         end
      end
   end

   // ****************************************
   // Request qualification and take sequence
   // ****************************************
   tlp_qualify u_qualify (
      .flag     (flag_ff),
      .enable   (enable_ff),
      .prio     (prio_ff),
      .prioMode (prioMode_ff),
      .highEn   (highEn_ff),
      .lowEn    (lowEn_ff),
      .hiActive (hiActive_ff),
      .hiReq    (hiReq),
      .loReq    (loReq)
   );

   assign anyReq   = hiReq | loReq;
   assign takeHigh = hiReq | ~prioMode_ff;
   assign takeNow  = (state_ff == ST_WAIT) & instrEn_ff & anyReq
                   & (waitCnt_ff == LAT_WAIT);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff   <= ST_IDLE;
         waitCnt_ff <= 2'h0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               waitCnt_ff <= 2'h0;
               if (instrEn_ff && anyReq) begin
                  state_ff <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!anyReq) begin
                  state_ff <= ST_IDLE;
               end else if (takeNow) begin
                  state_ff <= ST_TAKE;
               end else if (instrEn_ff) begin
                  waitCnt_ff <= waitCnt_ff + 2'h1;
               end
            end
            ST_TAKE: begin
               state_ff <= ST_IDLE;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Take pulse asks the core to push the return address and jump
   always_ff @(posedge clk) begin
      if (rst) begin
         vecReq_ff <= '0;
      end else begin
         vecReq_ff.take <= takeNow;
         if (takeNow) begin
            vecReq_ff.high   <= takeHigh;
            vecReq_ff.vector <= takeHigh ? VEC_HIGH : VEC_LOW;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqOut_ff <= 1'b0;
      end else begin
         irqOut_ff <= |(flag_ff & enable_ff);
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign apbRsp     = apbRsp_ff;
   assign vecReq     = vecReq_ff;
   assign instrCycle = instrEn_ff;
   assign irqOut     = irqOut_ff;

endmodule

/* dv/tlp_irq_checker.sv */
`timescale 1ns/1ps
module tlp_irq_checker
   import tlp_pkg::*;
(
   // Clock and reset
   input wire logic         clk,
   input wire logic         rst,
   // Register port
   input wire tlp_apb_req_t apbReq,
   input wire tlp_apb_rsp_t apbRsp,
   // Core side
   input wire tlp_vec_t     vecReq,
   input wire logic         instrCycle
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence answer_s;
      !apbRsp.pready ##1 apbRsp.pready;
   endsequence
   sequence quiet_s;
      !vecReq.take [*8];
   endsequence

   apb_answer_a: assert property (apbReq.psel && !apbReq.penable |=> answer_s)
      else $error("APB answer not in second access cycle");
   err_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready && apbReq.penable)
      else $error("Error response outside access");
   idle_data_a: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
      else $error("Read data outside response");
   vec_value_a: assert property (
      vecReq.take |-> vecReq.vector == (vecReq.high ? VEC_HIGH : VEC_LOW))
      else $error("Vector does not match level");
   take_gap_a: assert property (vecReq.take |=> quiet_s)
      else $error("Takes too close together");
   take_cycle_a: assert property (vecReq.take |-> $past(instrCycle))
      else $error("Take not after instruction cycle");
   vec_hold_a: assert property (
      !vecReq.take |-> $stable(vecReq.vector) && $stable(vecReq.high))
      else $error("Vector moved without take");
   instr_period_a: assert property (instrCycle |=> !instrCycle [*3] ##1 instrCycle)
      else $error("Instruction cycle period wrong");
endmodule

bind tlp_irq_ctrl tlp_irq_checker u_tlp_irq_checker (
   .clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
   .vecReq(vecReq), .instrCycle(instrCycle));

/* dv/tlp_core_model.sv */
`timescale 1ns/1ps
module tlp_core_model
   import tlp_pkg::*;
(
   // Clock and reset
   input wire logic     clk,
   input wire logic     rst,
   // Controller side
   input wire tlp_vec_t vecReq,
   output logic         retFromHandler,
   // Bench side
   input wire logic     retGo,
   output logic [15:0]  pcNow,
   output logic [3:0]   depth
);
   // Stack depth stands in for pushed return addresses
   always_ff @(posedge clk) begin
      if (rst) begin
         pcNow <= 16'h0000;
         depth <= 4'h0;
         retFromHandler <= 1'b0;
      end else begin
         retFromHandler <= retGo && depth != 4'h0;
         if (vecReq.take) begin
            pcNow <= vecReq.vector;
            depth <= depth + 4'h1;
         end else if (retGo && depth != 4'h0) begin
            depth <= depth - 4'h1;
         end
      end
   end
endmodule

/* dv/tlp_irq_ctrl_bench.sv */
`timescale 1ns/1ps
module tlp_irq_ctrl_bench
   import tlp_pkg::*;
;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   tlp_apb_req_t apbReq = '0;
   tlp_apb_rsp_t apbRsp;
   logic [1:0]   extPins = 2'h0;
   logic [3:0]   portIn = 4'h0;
   logic [4:0]   periphEvent = 5'h00;
   logic         retGo = 1'b0;
   logic         retFromHandler;
   logic         instrCycle;
   logic         irqOut;
   tlp_vec_t     vecReq;
   tlp_vec_t     seen;
   logic [15:0]  pcNow;
   logic [3:0]   depth;
   logic [31:0]  rd;
   logic         er;
   int           errTotal = 0;
   int           checkCount = 0;
   int           takes = 0;
   int           takeBase = 0;
   int           n;

   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      if (vecReq.take === 1'b1) begin
         takes++;
         seen = vecReq;
      end
   end

   tlp_irq_ctrl u_tlp_irq_ctrl (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
      .extPins(extPins), .portIn(portIn), .periphEvent(periphEvent),
      .retFromHandler(retFromHandler), .vecReq(vecReq), .instrCycle(instrCycle),
      .irqOut(irqOut));
   tlp_core_model u_tlp_core_model (.clk(clk), .rst(rst), .vecReq(vecReq),
      .retFromHandler(retFromHandler), .retGo(retGo), .pcNow(pcNow), .depth(depth));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic printVerdict;
      $display("Comparisons %0d, mismatches %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checkCount++;
      if (g !== e) begin
         errTotal++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (apbRsp.pready !== 1'b1 && k < 20);
      rd = apbRsp.prdata;
      er = apbRsp.pslverr;
      apbReq <= '0;
      if (apbRsp.pready !== 1'b1) begin
         errTotal++;
         printVerdict();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic run(input int c);
      repeat (c) @(posedge clk);
   endtask

   task automatic ev(input logic [4:0] p);
      periphEvent <= p;
      @(posedge clk);
      periphEvent <= 5'h00;
   endtask

   task automatic ret;
      retGo <= 1'b1;
      @(posedge clk);
      retGo <= 1'b0;
      run(3);
   endtask

   task automatic take1(input logic [15:0] v);
      run(40);
      chk(takes - takeBase, 1);
      chk(seen.vector, v);
      chk(seen.high, v == VEC_HIGH);
      chk(pcNow, v);
      takeBase = takes;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      run(8);
      rst <= 1'b0;
      run(1);
      for (int i = 0; i < 5; i++) rdc(12'(i * 4), 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk(er, 1'b1);
      wr(OFF_PRIO, 32'ha5);
      rdc(OFF_PRIO, 32'ha5);
      wr(OFF_PRIO, 32'h00);
      ev(5'h10);
      portIn <= 4'h1;
      extPins[1] <= 1'b1;
      run(10);
      rdc(OFF_FLAG, 32'h86);
      chk(irqOut, 1'b0);
      wr(OFF_FLAG, 32'hff);
      rdc(OFF_FLAG, 32'h00);
      wr(OFF_ENABLE, 32'h08);
      wr(OFF_IRQ_CTL, 32'h80);
      takeBase = takes;
      ev(5'h01);
      run(40);
      chk(takes - takeBase, 0);
      chk(irqOut, 1'b1);
      wr(OFF_IRQ_CTL, 32'hc0);
      take1(VEC_HIGH);
      rdc(OFF_IRQ_CTL, 32'h40);
      wr(OFF_FLAG, 32'h08);
      ret();
      rdc(OFF_IRQ_CTL, 32'hc0);
      wr(OFF_IRQ_CTL, 32'h80);
      wr(OFF_ENABLE, 32'h01);
      extPins[0] <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (vecReq.take !== 1'b1 && n < 40);
      chk(n >= 12 && n <= 22, 1'b1);
      take1(VEC_HIGH);
      rdc(OFF_IRQ_CTL, 32'h00);
      wr(OFF_FLAG, 32'h01);
      ret();
      wr(OFF_RESET_CTL, 32'h80);
      rdc(OFF_RESET_CTL, 32'h80);
      wr(OFF_PRIO, 32'h08);
      wr(OFF_ENABLE, 32'h18);
      wr(OFF_IRQ_CTL, 32'hc0);
      ev(5'h03);
      take1(VEC_HIGH);
      rdc(OFF_IRQ_CTL, 32'h40);
      rdc(OFF_FLAG, 32'h18);
      wr(OFF_FLAG, 32'h08);
      ret();
      take1(VEC_LOW);
      rdc(OFF_IRQ_CTL, 32'h80);
      ev(5'h01);
      take1(VEC_HIGH);
      rdc(OFF_IRQ_CTL, 32'h00);
      wr(OFF_FLAG, 32'h18);
      ret();
      rdc(OFF_IRQ_CTL, 32'h80);
      ret();
      rdc(OFF_IRQ_CTL, 32'hc0);
      chk(depth, 4'h0);
      printVerdict();
   end
endmodule
